//--- pkg/slg_pkg.sv
`default_nettype none
package slg_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DW = 16; // data and address width
    localparam int unsigned PCW = 23; // program counter width
    localparam int unsigned RAW = 4; // register port address width

    // ------------------------------------------------------------
    // register indices on the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] RA_SP = 4'h0; // stack pointer register
    localparam logic [3:0] RA_LIMIT = 4'h1; // stack limit register
    localparam logic [3:0] RA_GUARD = 4'h2; // protection enables
    localparam logic [3:0] RA_STATUS = 4'h3; // sticky events, write one to clear
    localparam logic [3:0] RA_MASK = 4'h4; // interrupt mask

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned EV_W = 4; // number of event bits
    localparam int unsigned EV_OVF = 0; // stack overflow above limit
    localparam int unsigned EV_UNF = 1; // stack underflow below floor
    localparam int unsigned EV_BOOT = 2; // boot secure ram violation
    localparam int unsigned EV_SEC = 3; // secure ram violation
    localparam int unsigned GD_BOOT_EN = 0; // boot secure ram guard enable
    localparam int unsigned GD_SEC_EN = 1; // secure ram guard enable

    // ------------------------------------------------------------
    // fixed addresses and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] STK_FLOOR = 16'h0800; // lowest legal stack address
    localparam logic [15:0] STK_STEP = 16'h0002; // one word
    localparam logic [15:0] SP_RST = 16'h0800; // stack pointer after reset
    localparam logic [1:0] GUARD_RST = 2'h0; // guards off after reset
    localparam logic [3:0] MASK_RST = 4'h0; // all events masked
    localparam logic [15:0] BRAM_LO = 16'h0800; // boot secure ram segment
    localparam logic [15:0] BRAM_HI = 16'h08FF;
    localparam logic [15:0] SRAM_LO = 16'h0900; // secure ram segment
    localparam logic [15:0] SRAM_HI = 16'h09FF;
    localparam logic [22:0] BFL_LO = 23'h000200; // boot flash segment
    localparam logic [22:0] BFL_HI = 23'h0007FF;
    localparam logic [22:0] SFL_LO = 23'h000800; // secure flash segment
    localparam logic [22:0] SFL_HI = 23'h000FFF;

    // ------------------------------------------------------------
    // kind of value pushed
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PK_DATA,
        PK_PC_LO,
        PK_CALL_HI,
        PK_EXC_HI
    } slg_push_kind_t;

endpackage
`default_nettype wire

//--- rtl/slg_seg_guard.sv
`timescale 1ns/1ps
`default_nettype none
// flags an access into a protected ram range made from code outside
// the flash range that owns it
module slg_seg_guard
#(
    parameter logic [15:0] RAM_LO = 16'h0000,
    parameter logic [15:0] RAM_HI = 16'h0000,
    parameter logic [22:0] CODE_LO = 23'h000000,
    parameter logic [22:0] CODE_HI = 23'h000000
)
(
    // control
    input wire logic en,
    input wire logic req,
    // access
    input wire logic [15:0] addr,
    input wire logic [22:0] code_addr,
    // result
    output logic deny
);

    logic in_ram; // address inside the protected range
    logic in_code; // executing code inside the owner range

    // --------------------------------------------------------
    // range compare
    // --------------------------------------------------------
    always_comb
    begin
        in_ram = (addr >= RAM_LO) && (addr <= RAM_HI);
        in_code = (code_addr >= CODE_LO) && (code_addr <= CODE_HI);
        deny = en && req && in_ram && !in_code;
    end

endmodule // slg_seg_guard
`default_nettype wire

//--- rtl/slg_stack_guard.sv
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module slg_stack_guard
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // stack operations from the core
    input wire logic stk_push,
    input wire logic stk_pop,
    input wire slg_pkg::slg_push_kind_t stk_kind,
    input wire logic [15:0] stk_data,
    input wire logic [22:0] pc_val,
    input wire logic [7:0] status_low_byte,
    // other data accesses from the core
    input wire logic acc_valid,
    input wire logic acc_we,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    input wire logic acc_via_sp,
    // read return to the core
    output logic acc_rvalid,
    output logic [15:0] acc_rdata,
    // data ram side
    output logic mem_we,
    output logic mem_re,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    // exception and interrupt
    output logic stack_trap,
    output logic irq
);

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    logic [15:0] sp_r, sp_nxt; // stack_pointer_register
    logic [15:0] lim_r, lim_nxt; // stack_limit_register, no reset
    logic [1:0] guard_r, guard_nxt; // guard enables
    logic [3:0] stat_r, stat_nxt; // sticky events
    logic [3:0] mask_r, mask_nxt; // event mask
    logic irq_r, irq_nxt; // interrupt level
    logic [15:0] rdat_r, rdat_nxt; // register read data
    logic trap_r, trap_nxt; // trap pulse
    logic we_r, we_nxt; // ram write strobe
    logic re_r, re_nxt; // ram read strobe
    logic [15:0] ma_r, ma_nxt; // ram address
    logic [15:0] mw_r, mw_nxt; // ram write data
    logic rd1_r, rd1_nxt; // read outstanding, stage 1
    logic blk1_r, blk1_nxt; // read denied, stage 1
    logic rd2_r, rd2_nxt; // read outstanding, stage 2
    logic blk2_r, blk2_nxt; // read denied, stage 2
    logic rv_r, rv_nxt; // read return valid
    logic [15:0] rv_d_r, rv_d_nxt; // read return data

    // --------------------------------------------------------
    // request decode
    // --------------------------------------------------------
    logic req; // any access this cycle
    logic req_we; // access writes
    logic [15:0] ea; // effective_address
    logic [15:0] push_val; // value a push writes
    logic chk_sp; // access formed through the stack pointer
    logic ovf; // above the limit
    logic unf; // below the floor
    logic deny_b; // boot secure ram refused
    logic deny_s; // secure ram refused
    logic wr_sp; // register write to the stack pointer
    logic wr_lim; // register write to the limit

    // stack ops outrank plain accesses, push outranks pop
    always_comb
    begin
        req = stk_push || stk_pop || acc_valid;
        req_we = stk_push || (!stk_pop && acc_valid && acc_we);
        // push uses the pointer, pop uses pointer minus one word
        if (stk_push)
        begin
            ea = sp_r;
        end
        else if (stk_pop)
        begin
            ea = sp_r - slg_pkg::STK_STEP;
        end
        else
        begin
            ea = acc_addr;
        end
        // value pushed by kind
        case (stk_kind)
            slg_pkg::PK_DATA: push_val = stk_data;
            slg_pkg::PK_PC_LO: push_val = pc_val[15:0];
            slg_pkg::PK_CALL_HI: push_val = {9'h000, pc_val[22:16]};
            slg_pkg::PK_EXC_HI: push_val = {status_low_byte, 1'h0, pc_val[22:16]};
            default: push_val = stk_data;
        endcase
        chk_sp = stk_push || stk_pop || (acc_valid && acc_via_sp);
        // equal to the limit is still legal, beyond it traps
        ovf = chk_sp && (ea > lim_r);
        // a pop from a pointer of zero wraps to the top of the range, so test the pointer too
        unf = chk_sp && ((ea < slg_pkg::STK_FLOOR) || (stk_pop && (sp_r < slg_pkg::STK_FLOOR)));
        wr_sp = reg_wr && (reg_addr == slg_pkg::RA_SP);
        wr_lim = reg_wr && (reg_addr == slg_pkg::RA_LIMIT);
    end

    // --------------------------------------------------------
    // protected ram segments
    // --------------------------------------------------------
    slg_seg_guard
    #(
        .RAM_LO(slg_pkg::BRAM_LO),
        .RAM_HI(slg_pkg::BRAM_HI),
        .CODE_LO(slg_pkg::BFL_LO),
        .CODE_HI(slg_pkg::BFL_HI)
    )
    u_boot_guard
    (
        .en(guard_r[slg_pkg::GD_BOOT_EN]),
        .req(req),
        .addr(ea),
        .code_addr(pc_val),
        .deny(deny_b)
    );

    slg_seg_guard
    #(
        .RAM_LO(slg_pkg::SRAM_LO),
        .RAM_HI(slg_pkg::SRAM_HI),
        .CODE_LO(slg_pkg::SFL_LO),
        .CODE_HI(slg_pkg::SFL_HI)
    )
    u_sec_guard
    (
        .en(guard_r[slg_pkg::GD_SEC_EN]),
        .req(req),
        .addr(ea),
        .code_addr(pc_val),
        .deny(deny_s)
    );

    // --------------------------------------------------------
    // pointer and limit next values
    // --------------------------------------------------------
    always_comb
    begin
        sp_nxt = sp_r;
        // register write wins over a stack op in the same cycle
        if (wr_sp)
        begin
            sp_nxt = {reg_wdata[15:1], 1'h0};
        end
        else if (stk_push)
        begin
            sp_nxt = sp_r + slg_pkg::STK_STEP;
        end
        else if (stk_pop)
        begin
            sp_nxt = sp_r - slg_pkg::STK_STEP;
        end
        // bit 0 of the limit is held at zero
        lim_nxt = wr_lim ? {reg_wdata[15:1], 1'h0} : lim_r;
    end

    // pointer register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sp_r <= slg_pkg::SP_RST;
        end
        else
        begin
            sp_r <= sp_nxt;
        end
    end

    // limit has no reset value
    always_ff @(posedge clk_sys)
    begin
        lim_r <= lim_nxt;
    end

    // --------------------------------------------------------
    // control, status, interrupt and register reads
    // --------------------------------------------------------
    always_comb
    begin
        guard_nxt = guard_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        if (reg_wr && (reg_addr == slg_pkg::RA_GUARD))
        begin
            guard_nxt = reg_wdata[1:0];
        end
        if (reg_wr && (reg_addr == slg_pkg::RA_MASK))
        begin
            mask_nxt = reg_wdata[3:0];
        end
        // clear by writing one, a new event wins over the clear
        if (reg_wr && (reg_addr == slg_pkg::RA_STATUS))
        begin
            stat_nxt = stat_nxt & ~reg_wdata[3:0];
        end
        stat_nxt[slg_pkg::EV_OVF] = stat_nxt[slg_pkg::EV_OVF] | ovf;
        stat_nxt[slg_pkg::EV_UNF] = stat_nxt[slg_pkg::EV_UNF] | unf;
        stat_nxt[slg_pkg::EV_BOOT] = stat_nxt[slg_pkg::EV_BOOT] | deny_b;
        stat_nxt[slg_pkg::EV_SEC] = stat_nxt[slg_pkg::EV_SEC] | deny_s;
        irq_nxt = |(stat_nxt & mask_nxt);
        // one trap pulse per offending access
        trap_nxt = ovf || unf;
        // read data stand only in the cycle after the strobe
        rdat_nxt = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                slg_pkg::RA_SP: rdat_nxt = sp_r;
                slg_pkg::RA_LIMIT: rdat_nxt = lim_r;
                slg_pkg::RA_GUARD: rdat_nxt = {14'h0000, guard_r};
                slg_pkg::RA_STATUS: rdat_nxt = {12'h000, stat_r};
                slg_pkg::RA_MASK: rdat_nxt = {12'h000, mask_r};
                default: rdat_nxt = 16'h0000;
            endcase
        end
    end

    // control registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            guard_r <= slg_pkg::GUARD_RST;
            mask_r <= slg_pkg::MASK_RST;
            stat_r <= 4'h0;
            irq_r <= 1'h0;
            trap_r <= 1'h0;
            rdat_r <= 16'h0000;
        end
        else
        begin
            guard_r <= guard_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
            trap_r <= trap_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // --------------------------------------------------------
    // ram request and read return pipeline
    // --------------------------------------------------------
    always_comb
    begin
        // refused writes are dropped, refused reads never reach ram
        we_nxt = req && req_we && !(deny_b || deny_s);
        re_nxt = req && !req_we && !(deny_b || deny_s);
        ma_nxt = req ? ea : ma_r;
        mw_nxt = stk_push ? push_val : (req ? acc_wdata : mw_r);
        rd1_nxt = req && !req_we;
        blk1_nxt = deny_b || deny_s;
        rd2_nxt = rd1_r;
        blk2_nxt = blk1_r;
        rv_nxt = rd2_r;
        // refused read returns zero
        rv_d_nxt = (rd2_r && !blk2_r) ? mem_rdata : 16'h0000;
    end

    // pipeline registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            we_r <= 1'h0;
            re_r <= 1'h0;
            ma_r <= 16'h0000;
            mw_r <= 16'h0000;
            rd1_r <= 1'h0;
            blk1_r <= 1'h0;
            rd2_r <= 1'h0;
            blk2_r <= 1'h0;
            rv_r <= 1'h0;
            rv_d_r <= 16'h0000;
        end
        else
        begin
            we_r <= we_nxt;
            re_r <= re_nxt;
            ma_r <= ma_nxt;
            mw_r <= mw_nxt;
            rd1_r <= rd1_nxt;
            blk1_r <= blk1_nxt;
            rd2_r <= rd2_nxt;
            blk2_r <= blk2_nxt;
            rv_r <= rv_nxt;
            rv_d_r <= rv_d_nxt;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdat_r;
    assign acc_rvalid = rv_r;
    assign acc_rdata = rv_d_r;
    assign mem_we = we_r;
    assign mem_re = re_r;
    assign mem_addr = ma_r;
    assign mem_wdata = mw_r;
    assign stack_trap = trap_r;
    assign irq = irq_r;

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    a_push_post_inc: assert property (stk_push && !wr_sp |=> sp_r == $past(sp_r) + 16'h0002)
        else $error("push did not advance pointer by one word");
    a_pop_pre_dec: assert property (stk_pop && !stk_push |=> mem_addr == $past(sp_r) - 16'h0002
        && mem_re == !($past(deny_b) || $past(deny_s)))
        else $error("pop did not read below pointer");
    a_push_free_word: assert property (stk_push && !(deny_b || deny_s) |=> mem_we && mem_addr == $past(sp_r))
        else $error("push did not write at pointer");
    a_call_msb_zero: assert property (stk_push && stk_kind == slg_pkg::PK_CALL_HI |=> mem_wdata[15] == 1'b0)
        else $error("call push msb not zero");
    a_exc_low_byte: assert property (stk_push && stk_kind == slg_pkg::PK_EXC_HI
        |=> mem_wdata[15:8] == $past(status_low_byte))
        else $error("exception push lacks status low byte");
    a_limit_bit0: assert property (wr_lim |=> lim_r == ($past(reg_wdata) & 16'hFFFE))
        else $error("limit write not aligned");
    a_push_at_limit: assert property (stk_push && sp_r == lim_r && sp_r >= 16'h0800 |=> !stack_trap)
        else $error("push at limit trapped");
    a_push_over: assert property (stk_push && sp_r > lim_r |=> stack_trap
        ##1 (stack_trap == ($past(ovf) || $past(unf))))
        else $error("push beyond limit missed trap");
    a_floor_trap: assert property (stk_pop && !stk_push && sp_r < 16'h0802 |=> stack_trap)
        else $error("underflow missed trap");
    a_boot_drop: assert property (deny_b && req_we |=> !mem_we)
        else $error("boot segment write not dropped");
    a_sec_zero: assert property (deny_s && !req_we |-> ##3 acc_rvalid && acc_rdata == 16'h0000)
        else $error("secure segment read not zeroed");
    a_trap_single: assert property (!(ovf || unf) |=> !stack_trap)
        else $error("trap without violation");

endmodule // slg_stack_guard
`default_nettype wire

//--- tb/slg_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module slg_ram_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // ram side of the guard
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] ram_r [0:255]; // word store, indexed by address bits 8:1

    // answer in the cycle after the read strobe only; a toggling
    // pattern otherwise so that stale data never looks valid
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_rdata <= 16'h5A5A;
        end
        else
        begin
            if (mem_we)
            begin
                ram_r[mem_addr[8:1]] <= mem_wdata;
            end
            if (mem_re)
            begin
                mem_rdata <= ram_r[mem_addr[8:1]];
            end
            else
            begin
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule // slg_ram_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys, rstn, reg_wr, reg_rd, stk_push, stk_pop, acc_valid, acc_we, acc_via_sp;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, stk_data, acc_addr, acc_wdata, acc_rdata;
    logic [22:0] pc_val;
    logic [7:0] status_low_byte;
    slg_pkg::slg_push_kind_t stk_kind;
    logic acc_rvalid, mem_we, mem_re, stack_trap, irq;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, rv;
    int mismatches, cmp_count;

    // ------------------------------------------------------------
    // design and far-side ram
    // ------------------------------------------------------------
    slg_stack_guard i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stk_push(stk_push), .stk_pop(stk_pop),
        .stk_kind(stk_kind), .stk_data(stk_data), .pc_val(pc_val), .status_low_byte(status_low_byte),
        .acc_valid(acc_valid), .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_via_sp(acc_via_sp), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata), .mem_we(mem_we),
        .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .stack_trap(stack_trap), .irq(irq));
    slg_ram_model i_ram (.clk_sys(clk_sys), .rstn(rstn), .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // whole sequence needs well under 200 cycles
    initial
    begin
        #(25 * 2000);
        mismatches++;
        results();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results();
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // let n edges pass, then sample settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // one stack operation: push when psh, else pop
    task automatic stk(input logic psh, input slg_pkg::slg_push_kind_t k, input logic [15:0] d);
        @(posedge clk_sys);
        stk_push <= psh;
        stk_pop <= !psh;
        stk_kind <= k;
        stk_data <= d;
        @(posedge clk_sys);
        stk_push <= 1'b0;
        stk_pop <= 1'b0;
        #1;
    endtask
    task automatic acc(input logic we, input logic [15:0] a, input logic [15:0] d, input logic via);
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_we <= we;
        acc_addr <= a;
        acc_wdata <= d;
        acc_via_sp <= via;
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        rstn = 1'b0;
        {reg_wr, reg_rd, stk_push, stk_pop, acc_valid, acc_we, acc_via_sp} = '0;
        reg_addr = 4'h0;
        {reg_wdata, stk_data, acc_addr, acc_wdata} = '0;
        stk_kind = slg_pkg::PK_DATA;
        pc_val = 23'h5ABCDE;
        status_low_byte = 8'hC3;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        // reset values and an unmapped index
        rd(slg_pkg::RA_SP, rv); chk(rv, slg_pkg::SP_RST);
        rd(slg_pkg::RA_GUARD, rv); chk(rv, 16'h0000);
        rd(slg_pkg::RA_STATUS, rv); chk(rv, 16'h0000);
        rd(4'h5, rv); chk(rv, 16'h0000);
        // limit keeps bit 0 clear
        wr(slg_pkg::RA_LIMIT, 16'h0A11);
        rd(slg_pkg::RA_LIMIT, rv); chk(rv, 16'h0A10);
        // data push writes at pointer, then moves up one word
        stk(1'b1, slg_pkg::PK_DATA, 16'h1234);
        chk(mem_we, 1'b1);
        chk(mem_addr, 16'h0800);
        chk(mem_wdata, 16'h1234);
        chk(stack_trap, 1'b0);
        rd(slg_pkg::RA_SP, rv); chk(rv, 16'h0802);
        // call frame: low word, then zero-extended high part
        stk(1'b1, slg_pkg::PK_PC_LO, 16'h0000);
        chk(mem_wdata, 16'hBCDE);
        stk(1'b1, slg_pkg::PK_CALL_HI, 16'h0000);
        chk(mem_wdata, 16'h005A);
        // exception high word carries the status low byte on top
        stk(1'b1, slg_pkg::PK_EXC_HI, 16'h0000);
        chk(mem_addr, 16'h0806);
        chk(mem_wdata, 16'hC35A);
        // pop pre-decrements and returns the last pushed word
        stk(1'b0, slg_pkg::PK_DATA, 16'h0000);
        chk(mem_re, 1'b1);
        chk(mem_addr, 16'h0806);
        settle(2);
        chk(acc_rvalid, 1'b1);
        chk(acc_rdata, 16'hC35A);
        // limit boundary; the core never reads through the pointer right after this write
        wr(slg_pkg::RA_LIMIT, 16'h0808);
        stk(1'b1, slg_pkg::PK_DATA, 16'h0001);
        chk(stack_trap, 1'b0);
        stk(1'b1, slg_pkg::PK_DATA, 16'h0002);
        chk(mem_addr, 16'h0808);
        chk(stack_trap, 1'b0);
        stk(1'b1, slg_pkg::PK_DATA, 16'h0003);
        chk(stack_trap, 1'b1);
        chk(mem_we, 1'b1);
        settle(1);
        chk(stack_trap, 1'b0);
        rd(slg_pkg::RA_STATUS, rv); chk(rv, 16'h0001);
        chk(irq, 1'b0);
        // unmask, then clear by writing one
        wr(slg_pkg::RA_MASK, 16'h000F);
        settle(1);
        chk(irq, 1'b1);
        wr(slg_pkg::RA_STATUS, 16'h0001);
        settle(1);
        chk(irq, 1'b0);
        // pointer-formed access above the limit, then one at the floor
        acc(1'b0, 16'h0900, 16'h0000, 1'b1);
        chk(stack_trap, 1'b1);
        acc(1'b0, 16'h0800, 16'h0000, 1'b1);
        chk(stack_trap, 1'b0);
        // pop from the floor goes below it
        wr(slg_pkg::RA_SP, 16'h0800);
        stk(1'b0, slg_pkg::PK_DATA, 16'h0000);
        chk(stack_trap, 1'b1);
        chk(mem_addr, 16'h07FE);
        rd(slg_pkg::RA_STATUS, rv); chk(rv, 16'h0003);
        wr(slg_pkg::RA_STATUS, 16'h000F);
        // protected segments
        wr(slg_pkg::RA_GUARD, 16'h0003);
        acc(1'b1, 16'h0810, 16'hAAAA, 1'b0);
        chk(mem_we, 1'b0);
        @(posedge clk_sys) pc_val <= 23'h000300;
        acc(1'b1, 16'h0810, 16'h55AA, 1'b0);
        chk(mem_we, 1'b1);
        acc(1'b0, 16'h0910, 16'h0000, 1'b0);
        chk(mem_re, 1'b0);
        settle(2);
        chk(acc_rvalid, 1'b1);
        chk(acc_rdata, 16'h0000);
        @(posedge clk_sys) pc_val <= 23'h000900;
        acc(1'b0, 16'h0810, 16'h0000, 1'b0);
        chk(mem_re, 1'b0);
        acc(1'b0, 16'h0910, 16'h0000, 1'b0);
        chk(mem_re, 1'b1);
        rd(slg_pkg::RA_STATUS, rv); chk(rv, 16'h000C);
        chk(irq, 1'b1);
        results();
    end
endmodule // testbench
`default_nettype wire
